// ==== verilog/tre_encoder.sv ====
// Result encoder: latches range per conversion, stores local/remote bytes.
`timescale 1ns/1ns
module tre_encoder (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] cfg1_i,
    input wire logic conv_start_i,
    input wire logic conv_done_i,
    input wire logic chan_i,
    input wire logic signed [tre_pkg::TEMP_W-1:0] temp_i,
    output logic busy_o,
    output logic ext_active_o,
    output logic [7:0] local_high_o,
    output logic [7:0] local_low_o,
    output logic [7:0] remote_high_o,
    output logic [7:0] remote_low_o,
    output logic local_upd_o,
    output logic remote_upd_o
);

    typedef struct packed {
        tre_pkg::tre_state_type state;
        logic ext;
        logic [7:0] loc_hi;
        logic [7:0] loc_lo;
        logic [7:0] rem_hi;
        logic [7:0] rem_lo;
        logic loc_upd;
        logic rem_upd;
    } tre_regs_type;

    tre_regs_type state_reg;
    tre_regs_type state_next;

    logic [7:0] code_high;
    logic [7:0] code_low;
    logic done_taken;

    ////////////////////////////////////////////////////////////////////////

    tre_code_calc u_calc (
        .temp_i(temp_i),
        .ext_i(state_reg.ext),
        .high_o(code_high),
        .low_o(code_low)
    );

    // A done pulse outside a conversion carries no valid range: dropped
    assign done_taken = (state_reg.state == tre_pkg::TRE_CONV) && conv_done_i;

    always_comb begin
        state_next = state_reg;
        state_next.loc_upd = 1'b0;
        state_next.rem_upd = 1'b0;
        unique case (state_reg.state)
            tre_pkg::TRE_IDLE: begin
                if (conv_start_i) begin
                    // Range sampled once so a mid-conversion change waits
                    state_next.ext = cfg1_i[tre_pkg::CFG_EXT_BIT];
                    state_next.state = tre_pkg::TRE_CONV;
                end
            end
            tre_pkg::TRE_CONV: begin
                if (conv_done_i) begin
                    state_next.state = tre_pkg::TRE_IDLE;
                    // Both bytes written in one edge from one result
                    if (chan_i == tre_pkg::CH_REMOTE) begin
                        state_next.rem_hi = code_high;
                        state_next.rem_lo = code_low;
                        state_next.rem_upd = 1'b1;
                    end else begin
                        state_next.loc_hi = code_high;
                        state_next.loc_lo = code_low;
                        state_next.loc_upd = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg.state <= tre_pkg::TRE_IDLE;
            state_reg.ext <= tre_pkg::EXT_RST;
            state_reg.loc_hi <= tre_pkg::HIGH_RST;
            state_reg.loc_lo <= tre_pkg::LOW_RST;
            state_reg.rem_hi <= tre_pkg::HIGH_RST;
            state_reg.rem_lo <= tre_pkg::LOW_RST;
            state_reg.loc_upd <= 1'b0;
            state_reg.rem_upd <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign busy_o = (state_reg.state == tre_pkg::TRE_CONV);
    assign ext_active_o = state_reg.ext;
    assign local_high_o = state_reg.loc_hi;
    assign local_low_o = state_reg.loc_lo;
    assign remote_high_o = state_reg.rem_hi;
    assign remote_low_o = state_reg.rem_lo;
    assign local_upd_o = state_reg.loc_upd;
    assign remote_upd_o = state_reg.rem_upd;

    ////////////////////////////////////////////////////////////////////////
    // Checks, written against the raw input so the calc block is covered

    function automatic logic signed [9:0] tre_whole(
        input logic signed [tre_pkg::TEMP_W-1:0] t
    );
        tre_whole = {t[tre_pkg::TEMP_W-1],
                     t[tre_pkg::TEMP_W-1:tre_pkg::FRAC_W]};
    endfunction : tre_whole

    logic signed [9:0] raw_whole;
    logic signed [9:0] raw_biased;
    logic [7:0] whole_code;
    logic [7:0] biased_code;
    logic [3:0] raw_frac;
    logic raw_in_range;
    logic [7:0] upd_hi;
    logic [7:0] upd_lo;
    logic any_upd;

    // Expected codes rebuilt from the raw input, not from the calc block
    assign raw_whole = tre_whole(temp_i);
    assign raw_biased = raw_whole + tre_pkg::EXT_OFFSET;
    assign whole_code = raw_whole[7:0];
    assign biased_code = raw_biased[7:0];
    assign raw_frac = temp_i[tre_pkg::FRAC_W-1:0];
    // Range in force decides whether the code is clamped
    assign raw_in_range = state_reg.ext
        ? (raw_biased >= 10'sh000 && raw_biased <= tre_pkg::EXT_MAX)
        : (raw_whole >= 10'sh000 && raw_whole <= tre_pkg::STD_MAX);

    assign any_upd = state_reg.loc_upd || state_reg.rem_upd;
    assign upd_hi = state_reg.rem_upd ? state_reg.rem_hi : state_reg.loc_hi;
    assign upd_lo = state_reg.rem_upd ? state_reg.rem_lo : state_reg.loc_lo;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence done_seq;
        done_taken;
    endsequence

    sequence std_done_seq;
        done_taken && !state_reg.ext;
    endsequence

    sequence ext_done_seq;
        done_taken && state_reg.ext;
    endsequence

    property std_in_range_p;
        std_done_seq ##0 (raw_whole >= 10'sh000)
            ##0 (raw_whole <= tre_pkg::STD_MAX)
        |=> upd_hi == $past(whole_code);
    endproperty

    std_binary_a: assert property (std_in_range_p)
        else $error("standard code not equal to whole degrees");

    std_floor_a: assert property (
        std_done_seq ##0 temp_i[tre_pkg::TEMP_W-1]
        |=> upd_hi == tre_pkg::FLOOR_CODE && upd_lo == tre_pkg::LOW_RST)
        else $error("negative standard result not clamped to zero");

    std_cap_a: assert property (
        std_done_seq ##0 (raw_whole > tre_pkg::STD_MAX)
        |=> upd_hi == tre_pkg::STD_CAP_CODE)
        else $error("standard result above 127 not saturated");

    range_latch_a: assert property (
        (state_reg.state == tre_pkg::TRE_IDLE) && conv_start_i
        |=> busy_o && ext_active_o == $past(cfg1_i[tre_pkg::CFG_EXT_BIT]))
        else $error("range not taken from config bit at start");

    range_hold_a: assert property (
        busy_o ##1 busy_o |-> $stable(ext_active_o))
        else $error("range changed during a conversion");

    stored_keep_a: assert property (
        !done_taken |=> $stable(local_high_o) && $stable(local_low_o)
            && $stable(remote_high_o) && $stable(remote_low_o))
        else $error("stored result changed without a conversion");

    ext_offset_a: assert property (
        ext_done_seq ##0 (raw_biased >= 10'sh000)
            ##0 (raw_biased <= tre_pkg::EXT_MAX)
        |=> upd_hi == $past(biased_code))
        else $error("extended code not offset by 64");

    ext_clamp_a: assert property (
        ext_done_seq ##0 (raw_biased > tre_pkg::EXT_MAX)
        |=> upd_hi == tre_pkg::EXT_CAP_CODE)
        else $error("extended result above 191 not saturated");

    ext_floor_a: assert property (
        ext_done_seq ##0 (raw_biased < 10'sh000)
        |=> upd_hi == tre_pkg::FLOOR_CODE && upd_lo == tre_pkg::LOW_RST)
        else $error("extended result below -64 not clamped to zero");

    frac_pair_a: assert property (
        done_seq ##0 raw_in_range
        |=> any_upd && upd_lo == {$past(raw_frac), 4'h0})
        else $error("low byte not the sixteenths of the result");

    clamp_low_a: assert property (
        done_seq ##0 !raw_in_range
        |=> any_upd && upd_lo == tre_pkg::LOW_RST)
        else $error("clamped result low byte not zero");

    low_nibble_a: assert property (
        local_low_o[3:0] == 4'h0 && remote_low_o[3:0] == 4'h0)
        else $error("low nibble of a result byte not zero");

    pair_update_a: assert property (
        ($changed(local_high_o) || $changed(local_low_o)) |-> local_upd_o
            ##1 !local_upd_o)
        else $error("local bytes written outside a paired update");

    pair_remote_a: assert property (
        ($changed(remote_high_o) || $changed(remote_low_o)) |-> remote_upd_o
            ##1 !remote_upd_o)
        else $error("remote bytes written outside a paired update");

    upd_single_a: assert property (
        !(local_upd_o && remote_upd_o))
        else $error("both channels flagged updated at once");

    done_release_a: assert property (
        done_seq |=> !busy_o && any_upd)
        else $error("taken result not stored or conversion still busy");

    idle_done_a: assert property (
        !busy_o && conv_done_i |=> !any_upd)
        else $error("result stored from a done pulse while idle");

endmodule : tre_encoder

// ==== inc/tre_pkg.sv ====
// Constants and types for the temperature result encoder.
//
// Summary of operation
// - Standard format: unsigned whole degrees, 0 to 127.
// - Standard format: negative temperatures read high byte 00.
// - Standard format: above 127 reads high byte 7F.
// - Config bit two selects extended format.
// - Range change applies from next conversion only.
// - Extended format adds 64 to whole degrees.
// - Extended codes 00 to FF cover -64..191.
// - Two bytes: whole degrees, then fraction.
// - Fixed resolution of one sixteenth degree.
// - Fraction in upper nibble, lower nibble zero.
package tre_pkg;

    // Raw result: signed sixteenths of a degree
    localparam int TEMP_W = 13;
    localparam int FRAC_W = 4;
    localparam int WHOLE_W = TEMP_W - FRAC_W;

    localparam int CFG_EXT_BIT = 2;

    localparam logic signed [9:0] EXT_OFFSET = 10'sh040;
    localparam logic signed [9:0] STD_MAX = 10'sh07F;
    localparam logic signed [9:0] EXT_MAX = 10'sh0FF;
    localparam logic [7:0] STD_CAP_CODE = 8'h7F;
    localparam logic [7:0] EXT_CAP_CODE = 8'hFF;
    localparam logic [7:0] FLOOR_CODE = 8'h00;

    localparam logic [7:0] HIGH_RST = 8'h00;
    localparam logic [7:0] LOW_RST = 8'h00;
    localparam logic EXT_RST = 1'b0;

    localparam logic CH_LOCAL = 1'b0;
    localparam logic CH_REMOTE = 1'b1;

    typedef enum logic [0:0] {
        TRE_IDLE = 1'b0,
        TRE_CONV = 1'b1
    } tre_state_type;

endpackage : tre_pkg

// ==== verilog/tre_code_calc.sv ====
// Combinational mapping of a raw temperature to high and low result bytes.
`timescale 1ns/1ns
module tre_code_calc (
    input wire logic signed [tre_pkg::TEMP_W-1:0] temp_i,
    input wire logic ext_i,
    output logic [7:0] high_o,
    output logic [7:0] low_o
);

    logic signed [9:0] whole;
    logic signed [9:0] biased;
    logic [7:0] frac_byte;

    // Floor division: fraction is always the positive remainder
    assign whole = {temp_i[tre_pkg::TEMP_W-1],
                    temp_i[tre_pkg::TEMP_W-1:tre_pkg::FRAC_W]};
    assign biased = whole + tre_pkg::EXT_OFFSET;
    assign frac_byte = {temp_i[tre_pkg::FRAC_W-1:0], 4'h0};

    always_comb begin
        high_o = tre_pkg::FLOOR_CODE;
        low_o = tre_pkg::LOW_RST;
        if (ext_i) begin
            if (biased < 10'sh000) begin
                high_o = tre_pkg::FLOOR_CODE;
            end else if (biased > tre_pkg::EXT_MAX) begin
                high_o = tre_pkg::EXT_CAP_CODE;
            end else begin
                high_o = biased[7:0];
                low_o = frac_byte;
            end
        end else begin
            if (whole < 10'sh000) begin
                high_o = tre_pkg::FLOOR_CODE;
            end else if (whole > tre_pkg::STD_MAX) begin
                high_o = tre_pkg::STD_CAP_CODE;
            end else begin
                high_o = whole[7:0];
                low_o = frac_byte;
            end
        end
    end

endmodule : tre_code_calc

// ==== sim/test_temperature_result_encoder.sv ====
// Self-checking bench for the temperature result encoder.
`timescale 1ns/1ns
module test_temperature_result_encoder;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] cfg1_i = 8'h00;
    logic conv_start_i = 1'b0;
    logic conv_done_i = 1'b0;
    logic chan_i = 1'b0;
    logic signed [tre_pkg::TEMP_W-1:0] temp_i = '0;
    logic busy_o, ext_active_o, local_upd_o, remote_upd_o;
    logic [7:0] local_high_o, local_low_o, remote_high_o, remote_low_o;
    int num_errors = 0;
    int n_compared = 0;
    int temps[10] = '{-1040, -1024, -8, 0, 25, 400, 2032, 2047, 3071, 3200};

    tre_encoder u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .cfg1_i(cfg1_i), .conv_start_i(conv_start_i),
        .conv_done_i(conv_done_i), .chan_i(chan_i), .temp_i(temp_i),
        .busy_o(busy_o), .ext_active_o(ext_active_o),
        .local_high_o(local_high_o), .local_low_o(local_low_o),
        .remote_high_o(remote_high_o), .remote_low_o(remote_low_o),
        .local_upd_o(local_upd_o), .remote_upd_o(remote_upd_o));

    always #2 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen,
                exp);
        end
    endtask : check

    task automatic final_report;
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // Floor of sixteenths, clamp per format; clamped codes carry low 00
    function automatic logic [15:0] expect_bytes(input int t, input bit ext);
        int w;
        int mx;
        w = (t >>> 4) + (ext ? 64 : 0);
        mx = ext ? 255 : 127;
        if (w < 0)
            return 16'h0000;
        if (w > mx)
            return {mx[7:0], 8'h00};
        return {w[7:0], t[3:0], 4'h0};
    endfunction : expect_bytes

    ////////////////////////////////////////////////////////////////////////
    // One full conversion; cfg_mid is applied while busy
    task automatic run_conv(input logic [7:0] cfg, input logic ch,
        input int t, input logic [7:0] cfg_mid);
        logic [15:0] e;
        logic [15:0] other;
        logic [15:0] upd_e;
        e = expect_bytes(t, cfg[2]);
        upd_e = ch ? 16'h0002 : 16'h0001;
        other = ch ? {local_high_o, local_low_o}
                   : {remote_high_o, remote_low_o};
        @(negedge clk_sys_i);
        cfg1_i = cfg;
        conv_start_i = 1'b1;
        @(negedge clk_sys_i);
        conv_start_i = 1'b0;
        cfg1_i = cfg_mid;
        check({15'h0000, busy_o}, 16'h0001);
        check({15'h0000, ext_active_o}, {15'h0000, cfg[2]});
        conv_done_i = 1'b1;
        chan_i = ch;
        temp_i = t[12:0];
        @(negedge clk_sys_i);
        conv_done_i = 1'b0;
        check({15'h0000, busy_o}, 16'h0000);
        check({14'h0000, remote_upd_o, local_upd_o}, upd_e);
        if (ch)
            check({remote_high_o, remote_low_o}, e);
        else
            check({local_high_o, local_low_o}, e);
        if (ch)
            check({local_high_o, local_low_o}, other);
        else
            check({remote_high_o, remote_low_o}, other);
        @(negedge clk_sys_i);
        check({14'h0000, remote_upd_o, local_upd_o}, 16'h0000);
    endtask : run_conv

    // Done while idle and start while busy must both be ignored
    task automatic refusals;
        logic [15:0] keep;
        keep = {local_high_o, local_low_o};
        @(negedge clk_sys_i);
        conv_done_i = 1'b1;
        chan_i = 1'b0;
        temp_i = 13'h0123;
        @(negedge clk_sys_i);
        conv_done_i = 1'b0;
        check({15'h0000, local_upd_o}, 16'h0000);
        check({local_high_o, local_low_o}, keep);
        conv_start_i = 1'b1;
        @(negedge clk_sys_i);
        cfg1_i = 8'h04;
        @(negedge clk_sys_i);
        conv_start_i = 1'b0;
        check({15'h0000, ext_active_o}, 16'h0000);
        conv_done_i = 1'b1;
        temp_i = 13'h0F00;
        @(negedge clk_sys_i);
        conv_done_i = 1'b0;
        check({local_high_o, local_low_o}, 16'h7F00);
    endtask : refusals

    // Reset in mid-conversion clears everything; work resumes after it
    task automatic reset_mid_conv;
        @(negedge clk_sys_i);
        cfg1_i = 8'h04;
        conv_start_i = 1'b1;
        @(negedge clk_sys_i);
        conv_start_i = 1'b0;
        check({14'h0000, busy_o, ext_active_o}, 16'h0003);
        rst_n_i = 1'b0;
        #1;
        check({14'h0000, busy_o, ext_active_o}, 16'h0000);
        check({local_high_o, local_low_o}, 16'h0000);
        check({remote_high_o, remote_low_o}, 16'h0000);
        repeat (2) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        check({14'h0000, remote_upd_o, local_upd_o}, 16'h0000);
    endtask : reset_mid_conv

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        check({local_high_o, local_low_o}, 16'h0000);
        check({remote_high_o, remote_low_o}, 16'h0000);
        check({14'h0000, busy_o, ext_active_o}, 16'h0000);
        foreach (temps[i]) begin
            run_conv(8'h00, 1'(i % 2), temps[i], 8'h00);
            run_conv(8'h04, 1'(i % 2), temps[i], 8'h04);
        end
        run_conv(8'hFB, 1'b0, 3200, 8'hFB);
        run_conv(8'h00, 1'b1, -160, 8'h04);
        run_conv(8'h04, 1'b0, -160, 8'h00);
        refusals();
        run_conv(8'h04, 1'b1, 400, 8'h04);
        reset_mid_conv();
        run_conv(8'h04, 1'b0, 25, 8'h00);
        final_report();
    end

    initial begin
        #20000;
        num_errors++;
        final_report();
    end
endmodule : test_temperature_result_encoder
